// ===== core/bcq_pkg.sv
`default_nettype none
package bcq_pkg;
  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned PAGE_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_MODE = 8'h28;
  localparam logic [7:0] IDX_CTRL = 8'h29;
  localparam logic [7:0] IDX_CMPA = 8'h2a;
  localparam logic [7:0] IDX_CMPB = 8'h2b;
  localparam logic [7:0] IDX_STAT = 8'h30;
  localparam logic [7:0] IDX_CLR = 8'h31;
  localparam logic [7:0] IDX_IEN = 8'h32;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_AMH = 7;
  localparam int unsigned CTRL_AML = 6;
  localparam int unsigned CTRL_BMH = 5;
  localparam int unsigned CTRL_BML = 4;
  localparam int unsigned CTRL_ADE = 3;
  localparam int unsigned CTRL_ADV = 2;
  localparam int unsigned CTRL_BDE = 1;
  localparam int unsigned CTRL_BDV = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int unsigned MODE_BKP = 0;
  localparam int unsigned MODE_FULL = 1;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam int unsigned CMP_W = 22;
  localparam int unsigned CMP_EXT_LSB = 16;
  localparam logic [21:0] CMP_RST = 22'h000000;
  localparam int unsigned IRQ_FIRST = 0;
  localparam int unsigned IRQ_SECOND = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Byte address to register index
  function automatic logic [7:0] reg_index(input logic [7:0] a);
    return {2'h0, a[7:2]};
  endfunction
endpackage
`default_nettype wire

// ===== core/bcq_addr_cmp.sv
`timescale 1ns/100ps
`default_nettype none
// Masked paged address compare with direction qualifier
module bcq_addr_cmp
  import bcq_pkg::*;
(
  input wire logic mask_high,
  input wire logic mask_low,
  input wire logic page_sel,
  input wire logic [5:0] cmp_ext,
  input wire logic [7:0] cmp_high,
  input wire logic [7:0] cmp_low,
  input wire logic [15:0] addr,
  input wire logic [5:0] page,
  input wire logic dir_en,
  input wire logic dir_val,
  input wire logic is_read,
  output logic match
);
  // ----------------------------------------
  // Byte enables from the mask pair
  // ----------------------------------------
  logic low_on;
  logic high_on;
  logic page_only;
  logic ext_ok;
  logic high_ok;
  logic low_ok;
  logic dir_ok;

  // Low mask clear means full compare whatever the high bit
  assign low_on = ~mask_low;
  assign high_on = ~mask_low | ~mask_high;
  assign page_only = mask_high & mask_low;

  // Paged 20-bit or plain 16-bit compare
  assign ext_ok = page_sel ? (cmp_ext == page) : ~page_only;
  assign high_ok = page_sel ? (cmp_high[5:0] == addr[13:8])
                            : (cmp_high == addr[15:8]);
  assign low_ok = cmp_low == addr[7:0];

  // Direction: 0 matches writes, 1 matches reads
  assign dir_ok = ~dir_en | (dir_val == is_read);

  assign match = ext_ok & (~high_on | high_ok) & (~low_on | low_ok)
                 & dir_ok;
endmodule // bcq_addr_cmp
`default_nettype wire

// ===== core/bcq_breakpoint_qualifier.sv
`timescale 1ns/100ps
`default_nettype none
module bcq_breakpoint_qualifier
  import bcq_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic [bcq_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [bcq_pkg::AXI_DW-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [bcq_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [bcq_pkg::AXI_DW-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [15:0] CPU_DATA,
  input wire logic [bcq_pkg::PAGE_W-1:0] CPU_PAGE,
  input wire logic CPU_PAGE_SEL,
  input wire logic CPU_READ,
  input wire logic CPU_VALID,
  output logic FIRST_MATCH,
  output logic SECOND_MATCH,
  output logic IRQ
);
  import bcq_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [CMP_W-1:0] cmpa_reg;
  logic [CMP_W-1:0] cmpb_reg;
  logic [1:0] stat_reg;
  logic [1:0] ien_reg;
  logic first_reg;
  logic second_reg;
  logic [1:0] mode_next;
  logic [7:0] ctrl_next;
  logic [CMP_W-1:0] cmpa_next;
  logic [CMP_W-1:0] cmpb_next;
  logic [1:0] stat_next;
  logic [1:0] ien_next;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic [7:0] w_idx;
  logic [7:0] r_idx;

  // Ready only while enabled so no beat is lost when frozen
  assign S_AXI_AWREADY = CLK_EN & ~aw_held_reg & ~bvalid_reg;
  assign S_AXI_WREADY = CLK_EN & ~w_held_reg & ~bvalid_reg;
  assign S_AXI_ARREADY = CLK_EN & ~rvalid_reg;
  assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  assign wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign w_idx = reg_index(aw_addr_reg);
  assign r_idx = reg_index(S_AXI_ARADDR);
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;

  // Write decode
  logic wr_mode;
  logic wr_ctrl;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_clr;
  logic wr_ien;
  logic w_mapped;
  logic [31:0] w_merge_mode;
  logic [31:0] w_merge_ctrl;
  logic [31:0] w_merge_cmpa;
  logic [31:0] w_merge_cmpb;
  logic [31:0] w_merge_ien;
  logic [1:0] clr_bits;

  assign wr_mode = wr_go & (w_idx == IDX_MODE);
  assign wr_ctrl = wr_go & (w_idx == IDX_CTRL);
  assign wr_cmpa = wr_go & (w_idx == IDX_CMPA);
  assign wr_cmpb = wr_go & (w_idx == IDX_CMPB);
  assign wr_clr = wr_go & (w_idx == IDX_CLR);
  assign wr_ien = wr_go & (w_idx == IDX_IEN);
  assign w_mapped = (w_idx == IDX_MODE) | (w_idx == IDX_CTRL)
                    | (w_idx == IDX_CMPA) | (w_idx == IDX_CMPB)
                    | (w_idx == IDX_CLR) | (w_idx == IDX_IEN)
                    | (w_idx == IDX_STAT);
  assign w_merge_mode = wmerge({30'h0, mode_reg}, w_data_reg, w_strb_reg);
  assign w_merge_ctrl = wmerge({24'h0, ctrl_reg}, w_data_reg, w_strb_reg);
  assign w_merge_cmpa = wmerge({10'h0, cmpa_reg}, w_data_reg, w_strb_reg);
  assign w_merge_cmpb = wmerge({10'h0, cmpb_reg}, w_data_reg, w_strb_reg);
  assign w_merge_ien = wmerge({30'h0, ien_reg}, w_data_reg, w_strb_reg);
  assign clr_bits = (wr_clr & w_strb_reg[0]) ? w_data_reg[1:0] : 2'h0;

  // Next register values
  assign mode_next = wr_mode ? w_merge_mode[1:0] : mode_reg;
  assign cmpa_next = wr_cmpa ? w_merge_cmpa[CMP_W-1:0] : cmpa_reg;
  assign cmpb_next = wr_cmpb ? w_merge_cmpb[CMP_W-1:0] : cmpb_reg;
  assign ien_next = wr_ien ? w_merge_ien[1:0] : ien_reg;

  // First mask pair forced to zero whenever trace mode is in force
  logic [7:0] ctrl_wr;
  assign ctrl_wr = wr_ctrl ? w_merge_ctrl[7:0] : ctrl_reg;
  assign ctrl_next = mode_next[MODE_BKP] ? ctrl_wr
                     : {2'h0, ctrl_wr[5:0]};

  // Read mux
  logic [31:0] rd_mux;
  logic r_mapped;
  assign r_mapped = (r_idx == IDX_MODE) | (r_idx == IDX_CTRL)
                    | (r_idx == IDX_CMPA) | (r_idx == IDX_CMPB)
                    | (r_idx == IDX_CLR) | (r_idx == IDX_IEN)
                    | (r_idx == IDX_STAT);
  assign rd_mux = (r_idx == IDX_MODE) ? {30'h0, mode_reg}
                : (r_idx == IDX_CTRL) ? {24'h0, ctrl_reg}
                : (r_idx == IDX_CMPA) ? {10'h0, cmpa_reg}
                : (r_idx == IDX_CMPB) ? {10'h0, cmpb_reg}
                : (r_idx == IDX_STAT) ? {30'h0, stat_reg}
                : (r_idx == IDX_IEN) ? {30'h0, ien_reg}
                : 32'h0;

  // Write channel state
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (CLK_EN) begin
      if (aw_hs) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (w_hs) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel state
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end else if (CLK_EN) begin
      if (ar_hs) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Comparator qualification
  // ----------------------------------------
  logic trace_mode;
  logic full_mode;
  logic b_mh;
  logic b_ml;
  logic a_match;
  logic b_match;
  logic data_ok;
  logic first_hit;
  logic second_hit;

  assign trace_mode = ~mode_reg[MODE_BKP];
  assign full_mode = mode_reg[MODE_FULL];

  // Second mask steers addresses only in breakpoint dual, neither in trace nor in full mode
  assign b_mh = ~trace_mode & ~full_mode & ctrl_reg[CTRL_BMH];
  assign b_ml = ~trace_mode & ~full_mode & ctrl_reg[CTRL_BML];

  // First address comparator, masks held at zero in trace mode
  bcq_addr_cmp u_cmp_a (
    .mask_high(ctrl_reg[CTRL_AMH]),
    .mask_low(ctrl_reg[CTRL_AML]),
    .page_sel(CPU_PAGE_SEL),
    .cmp_ext(cmpa_reg[CMP_EXT_LSB +: PAGE_W]),
    .cmp_high(cmpa_reg[15:8]),
    .cmp_low(cmpa_reg[7:0]),
    .addr(CPU_ADDR),
    .page(CPU_PAGE),
    .dir_en(ctrl_reg[CTRL_ADE]),
    .dir_val(ctrl_reg[CTRL_ADV]),
    .is_read(CPU_READ),
    .match(a_match)
  );

  // Second address comparator, used in trace and breakpoint dual, not in full mode
  bcq_addr_cmp u_cmp_b (
    .mask_high(b_mh),
    .mask_low(b_ml),
    .page_sel(CPU_PAGE_SEL),
    .cmp_ext(cmpb_reg[CMP_EXT_LSB +: PAGE_W]),
    .cmp_high(cmpb_reg[15:8]),
    .cmp_low(cmpb_reg[7:0]),
    .addr(CPU_ADDR),
    .page(CPU_PAGE),
    .dir_en(ctrl_reg[CTRL_BDE]),
    .dir_val(ctrl_reg[CTRL_BDV]),
    .is_read(CPU_READ),
    .match(b_match)
  );

  // Data bytes in full mode; second extended bits never used
  assign data_ok = (ctrl_reg[CTRL_BMH] | (CPU_DATA[15:8] == cmpb_reg[15:8]))
                 & (ctrl_reg[CTRL_BML] | (CPU_DATA[7:0] == cmpb_reg[7:0]));

  // All qualifiers in one bus cycle
  assign first_hit = CPU_VALID & a_match & (~full_mode | data_ok);
  assign second_hit = CPU_VALID & ~full_mode & b_match;

  // ----------------------------------------
  // Registers, match outputs and interrupt
  // ----------------------------------------
  // Set beats a clear in the same cycle
  assign stat_next = (stat_reg & ~clr_bits) | {second_hit, first_hit};

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_reg <= MODE_RST;
      ctrl_reg <= CTRL_RST;
      cmpa_reg <= CMP_RST;
      cmpb_reg <= CMP_RST;
      stat_reg <= IRQ_RST;
      ien_reg <= IRQ_RST;
      first_reg <= 1'b0;
      second_reg <= 1'b0;
    end else if (CLK_EN) begin
      mode_reg <= mode_next;
      ctrl_reg <= ctrl_next;
      cmpa_reg <= cmpa_next;
      cmpb_reg <= cmpb_next;
      stat_reg <= stat_next;
      ien_reg <= ien_next;
      first_reg <= first_hit;
      second_reg <= second_hit;
    end
  end

  assign FIRST_MATCH = first_reg;
  assign SECOND_MATCH = second_reg;
  assign IRQ = |(stat_reg & ien_reg);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_trace_mask;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && !mode_next[MODE_BKP]) |=> (ctrl_reg[7:6] == 2'h0);
  endproperty
  a_trace_mask: assert property (p_trace_mask)
    else $error("first mask pair not held at zero in trace mode");

  property p_full_no_second;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && full_mode) |=> !SECOND_MATCH;
  endproperty
  a_full_no_second: assert property (p_full_no_second)
    else $error("second match reported in full mode");

  property p_need_valid;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && !CPU_VALID) |=> (!FIRST_MATCH && !SECOND_MATCH);
  endproperty
  a_need_valid: assert property (p_need_valid)
    else $error("match without a bus cycle");

  property p_dir_write;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && ctrl_reg[CTRL_ADE] && !ctrl_reg[CTRL_ADV] && CPU_READ)
      |=> !FIRST_MATCH;
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("write-only qualifier matched a read");

  property p_data_bytes;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && full_mode && ctrl_reg[5:4] == 2'h0
      && CPU_DATA != cmpb_reg[15:0]) |=> !FIRST_MATCH;
  endproperty
  a_data_bytes: assert property (p_data_bytes)
    else $error("full mode matched with differing data");

  property p_page_only;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && ctrl_reg[7:6] == 2'h3 && !CPU_PAGE_SEL) |=> !FIRST_MATCH;
  endproperty
  a_page_only: assert property (p_page_only)
    else $error("page-only mask matched without a page");

  property p_plain16;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && CPU_VALID && mode_reg == 2'h1 && !ctrl_reg[CTRL_BDE]
      && !ctrl_reg[CTRL_BML] && !CPU_PAGE_SEL
      && CPU_ADDR == cmpb_reg[15:0]) |=> SECOND_MATCH;
  endproperty
  a_plain16: assert property (p_plain16)
    else $error("16-bit compare missed");

  property p_paged20;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && CPU_VALID && !full_mode && !ctrl_reg[CTRL_BDE]
      && (trace_mode || !ctrl_reg[CTRL_BML]) && CPU_PAGE_SEL
      && CPU_PAGE == cmpb_reg[21:16]
      && CPU_ADDR[13:0] == cmpb_reg[13:0]) |=> SECOND_MATCH;
  endproperty
  a_paged20: assert property (p_paged20)
    else $error("20-bit paged compare missed");

  property p_range256;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && CPU_VALID && mode_reg == 2'h1 && !ctrl_reg[CTRL_BDE]
      && ctrl_reg[5:4] == 2'h1 && !CPU_PAGE_SEL
      && CPU_ADDR[15:8] == cmpb_reg[15:8]) |=> SECOND_MATCH;
  endproperty
  a_range256: assert property (p_range256)
    else $error("256-byte range compare missed");

  property p_set_wins;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && first_hit) |=> stat_reg[IRQ_FIRST];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("first match lost from status");

  c_full_hit: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    full_mode && FIRST_MATCH);
  c_second_hit: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    SECOND_MATCH);
  c_irq: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    IRQ && wr_clr);
endmodule // bcq_breakpoint_qualifier
`default_nettype wire

// ===== bench/bcq_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// CPU core bus model
// ----------------------------------------
module bcq_cpu_model (
  input wire logic clk,
  output logic [15:0] addr,
  output logic [15:0] data,
  output logic [5:0] page,
  output logic page_sel,
  output logic is_read,
  output logic valid
);
  // Idle bus at time zero
  initial begin
    addr = 16'h0000;
    data = 16'h0000;
    page = 6'h00;
    page_sel = 1'b0;
    is_read = 1'b0;
    valid = 1'b0;
  end

  // One bus cycle; released lines show inverted values, not stale ones
  task automatic bus_cycle(input logic [15:0] a, input logic [15:0] d,
                           input logic [5:0] p, input logic s,
                           input logic r);
    @(posedge clk);
    addr <= a;
    data <= d;
    page <= p;
    page_sel <= s;
    is_read <= r;
    valid <= 1'b1;
    @(posedge clk);
    addr <= ~a;
    data <= ~d;
    page <= ~p;
    page_sel <= ~s;
    is_read <= ~r;
    valid <= 1'b0;
  endtask
endmodule // bcq_cpu_model
`default_nettype wire

// ===== bench/bcq_breakpoint_qualifier_test.sv
`timescale 1ns/100ps
`default_nettype none
module bcq_breakpoint_qualifier_test;
  import bcq_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] ctrl;
    logic [15:0] addr;
    logic [15:0] data;
    logic [5:0] page;
    logic sel;
    logic rd;
    logic f;
    logic s;
  } bcq_row_s;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, first, second, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rv;
  logic [15:0] cpu_addr, cpu_data;
  logic [5:0] cpu_page;
  logic cpu_sel, cpu_rd, cpu_valid;
  int n_mismatch = 0;
  int n_tests = 0;
  // Compare values A={05,12,34}, B={2a,56,78}; mode 1 bkp, 2 full
  bcq_row_s rows [0:30] = '{
    '{2'h1,8'h00,16'h1234,16'h0000,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h1,8'h00,16'h1235,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h0},
    '{2'h1,8'h00,16'h1234,16'h0000,6'h05,1'h1,1'h0,1'h1,1'h0},
    '{2'h1,8'h00,16'hd234,16'h0000,6'h05,1'h1,1'h0,1'h1,1'h0},
    '{2'h1,8'h00,16'h1234,16'h0000,6'h06,1'h1,1'h0,1'h0,1'h0},
    '{2'h1,8'h40,16'h12ff,16'h0000,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h1,8'h40,16'h13ff,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h0},
    '{2'h1,8'h80,16'h12ff,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h0},
    '{2'h1,8'h80,16'h1234,16'h0000,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h1,8'hc0,16'h0000,16'h0000,6'h05,1'h1,1'h0,1'h1,1'h0},
    '{2'h1,8'hc0,16'h0000,16'h0000,6'h04,1'h1,1'h0,1'h0,1'h0},
    '{2'h1,8'h0c,16'h1234,16'h0000,6'h00,1'h0,1'h1,1'h1,1'h0},
    '{2'h1,8'h0c,16'h1234,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h0},
    '{2'h1,8'h08,16'h1234,16'h0000,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h1,8'h04,16'h1234,16'h0000,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h1,8'h00,16'h5678,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h1},
    '{2'h1,8'h10,16'h56aa,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h1},
    '{2'h1,8'h03,16'h5678,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h0},
    '{2'h1,8'h03,16'h5678,16'h0000,6'h00,1'h0,1'h1,1'h0,1'h1},
    '{2'h0,8'h10,16'h56aa,16'h0000,6'h00,1'h0,1'h0,1'h0,1'h0},
    '{2'h0,8'hc0,16'h1234,16'h0000,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h0,8'hc0,16'h0000,16'h0000,6'h05,1'h1,1'h0,1'h0,1'h0},
    '{2'h3,8'h00,16'h1234,16'h5678,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h3,8'h00,16'h1234,16'h5679,6'h00,1'h0,1'h0,1'h0,1'h0},
    '{2'h3,8'h10,16'h1234,16'h5600,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h3,8'h20,16'h1234,16'h0078,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h3,8'h30,16'h1234,16'h0000,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h2,8'h10,16'h1234,16'h5600,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h3,8'h03,16'h1234,16'h5678,6'h00,1'h0,1'h0,1'h1,1'h0},
    '{2'h3,8'h00,16'h1234,16'h5678,6'h05,1'h1,1'h0,1'h1,1'h0},
    '{2'h1,8'h00,16'h9678,16'h0000,6'h2a,1'h1,1'h0,1'h0,1'h1}};

  // ----------------------------------------
  // Clock, design and CPU model
  // ----------------------------------------
  always #4 clk = ~clk;

  bcq_breakpoint_qualifier DUT (.SYS_CLK(clk), .RESET_N(rst_n),
    .CLK_EN(clk_en), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CPU_ADDR(cpu_addr), .CPU_DATA(cpu_data), .CPU_PAGE(cpu_page),
    .CPU_PAGE_SEL(cpu_sel), .CPU_READ(cpu_rd), .CPU_VALID(cpu_valid),
    .FIRST_MATCH(first), .SECOND_MATCH(second), .IRQ(irq));

  bcq_cpu_model cpu (.clk(clk), .addr(cpu_addr), .data(cpu_data),
    .page(cpu_page), .page_sel(cpu_sel), .is_read(cpu_rd),
    .valid(cpu_valid));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ba(input logic [7:0] idx);
    return {idx[5:0], 2'h0};
  endfunction

  // Write: address and data offered together, readies sampled settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic a_ok, w_ok, done;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      a_ok = awvalid && (awready === 1'b1);
      w_ok = wvalid && (wready === 1'b1);
      done = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic a_ok, done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      a_ok = arvalid && (arready === 1'b1);
      done = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (a_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    axi_wr(ba(idx), d, resp);
    chk(32'(resp), 32'(RESP_OKAY));
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    axi_rd(ba(idx), rv, resp);
    chk(rv, exp);
    chk(32'(resp), 32'(RESP_OKAY));
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #200us;
    n_mismatch++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_CTRL, 32'h0);
    rd(IDX_MODE, 32'h0);
    chk(32'(irq), 32'h0);
    wr(IDX_CMPA, 32'h051234);
    wr(IDX_CMPB, 32'h2a5678);
    // Table rows: mode before control so the first mask pair survives
    for (int i = 0; i < 31; i++) begin
      wr(IDX_MODE, 32'(rows[i].mode));
      wr(IDX_CTRL, 32'(rows[i].ctrl));
      cpu.bus_cycle(rows[i].addr, rows[i].data, rows[i].page,
                    rows[i].sel, rows[i].rd);
      #1;
      chk(32'(first), 32'(rows[i].f));
      chk(32'(second), 32'(rows[i].s));
    end
    // Control layout and forced-zero mask in trace mode
    wr(IDX_MODE, 32'h1);
    wr(IDX_CTRL, 32'ha5);
    rd(IDX_CTRL, 32'ha5);
    wr(IDX_MODE, 32'h0);
    rd(IDX_CTRL, 32'h25);
    wr(IDX_CTRL, 32'hff);
    rd(IDX_CTRL, 32'h3f);
    // Unmapped place refuses both ways
    axi_wr(8'h00, 32'hffff, resp);
    chk(32'(resp), 32'(RESP_SLVERR));
    axi_rd(8'h00, rv, resp);
    chk(rv, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    // Interrupt: raise while masked, enable, clear
    wr(IDX_CLR, 32'h3);
    wr(IDX_IEN, 32'h0);
    wr(IDX_MODE, 32'h1);
    wr(IDX_CTRL, 32'h0);
    cpu.bus_cycle(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b0);
    rd(IDX_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(IDX_IEN, 32'h1);
    #1;
    chk(32'(irq), 32'h1);
    wr(IDX_CLR, 32'h1);
    #1;
    chk(32'(irq), 32'h0);
    rd(IDX_STAT, 32'h0);
    // Frozen clock enable: matching cycle ignored, readies low
    clk_en <= 1'b0;
    cpu.bus_cycle(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b0);
    #1;
    chk(32'(first), 32'h0);
    chk(32'(awready), 32'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(IDX_STAT, 32'h0);
    // Lane 0 only: upper bytes of the compare value kept
    wstrb <= 4'h1;
    wr(IDX_CMPA, 32'hffffffff);
    wstrb <= 4'hf;
    rd(IDX_CMPA, 32'h0512ff);
    // Reset in mid-run returns registers and matches to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_CMPA, 32'h0);
    rd(IDX_MODE, 32'h0);
    chk(32'(first), 32'h0);
    results();
  end
endmodule // bcq_breakpoint_qualifier_test
`default_nettype wire
